// ==== sts_task_sequencer.sv ====
// scaler task sequencer: two task pages, start conditions, field flag and sav/eav marking
`timescale 1ns/1ns
`default_nettype none
module sts_task_sequencer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // decoder timing
    input wire logic decoder_vertical_pulse_i,
    input wire logic decoder_hsync_ref_i,
    input wire logic dec_field_i,
    input wire logic std_60hz_i,
    // external stream timing
    input wire logic ext_vref_i,
    input wire logic ext_decoder_hsync_ref_i,
    input wire logic ext_sav_i,
    // acquisition window
    input wire logic vert_offset_reached_i,
    input wire logic horz_offset_reached_i,
    input wire logic offsets_passed_i,
    input wire logic task_done_i,
    // outputs
    output logic task_active_o,
    output logic task_b_sel_o,
    output logic sav_d6_o,
    output logic sav_d7_o,
    output logic gp_out_pin_0_o,
    output logic gp_out_pin_1_o
);
    sts_pkg::sts_core_t state_reg;
    sts_pkg::sts_core_t state_next;

    logic vpulse_fall;
    logic decoder_hsync_ref_rise;
    logic vref_fall;
    logic ext_src;
    logic vsync_evt;
    logic line_evt;
    logic line_ok;
    logic [7:0] line_thresh;
    logic [2:0] trig;
    logic soft_reset_n;
    logic win_ok;
    logic fid_ok;
    logic go_cond;
    logic [7:0] idx;
    sts_pkg::sts_task_cfg_t cur_cfg;
    logic cur_toggle;

    sts_edge u_vpulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(decoder_vertical_pulse_i),
        .rise_o(),
        .fall_o(vpulse_fall)
    );

    sts_edge u_decoder_hsync_ref (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(decoder_hsync_ref_i),
        .rise_o(decoder_hsync_ref_rise),
        .fall_o()
    );

    sts_edge u_vref (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(ext_vref_i),
        .rise_o(),
        .fall_o(vref_fall)
    );

    assign ext_src = state_reg.global_ctl[sts_pkg::GL_EXT_SRC_BIT];
    assign trig = {state_reg.trig_ctl[sts_pkg::TR_VTRIG_HI_BIT],
                   state_reg.trig_ctl[sts_pkg::TR_VTRIG_LO_BIT],
                   state_reg.trig_ctl[sts_pkg::TR_HTRIG_BIT]};
    assign vsync_evt = ext_src ? vref_fall : vpulse_fall;
    assign line_evt = ext_src ? ext_sav_i : decoder_hsync_ref_rise;

    always_comb begin
        if (ext_src) begin
            line_thresh = std_60hz_i ? sts_pkg::LINE_EXT_60 : sts_pkg::LINE_EXT_50;
        end else if (trig == 3'b010) begin
            // field 0 is the first field of a frame
            if (!state_reg.field_ident) begin
                line_thresh = std_60hz_i ? sts_pkg::LINE_DEC_F1_60 : sts_pkg::LINE_DEC_F1_50;
            end else begin
                line_thresh = std_60hz_i ? sts_pkg::LINE_DEC_F2_60 : sts_pkg::LINE_DEC_F2_50;
            end
        end else begin
            // combinations without a defined start line fall back to the base line
            line_thresh = std_60hz_i ? sts_pkg::LINE_DEC_BASE_60 : sts_pkg::LINE_DEC_BASE_50;
        end
    end

    sts_line_gate u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(vsync_evt),
        .line_i(line_evt),
        .thresh_i(line_thresh),
        .ok_o(line_ok)
    );

    assign soft_reset_n = state_reg.reset_ctl[sts_pkg::RS_SOFT_RESET_BIT];
    assign cur_cfg = state_reg.task_b ? state_reg.cfg_b : state_reg.cfg_a;
    assign cur_toggle = state_reg.task_b ? state_reg.toggle_b : state_reg.toggle_a;
    assign win_ok = vert_offset_reached_i & horz_offset_reached_i & line_ok;
    assign idx = wb_adr_i[9:2];

    always_comb begin
        case (cur_cfg.start_condition)
            sts_pkg::START_FID0: fid_ok = ~state_reg.field_ident;
            sts_pkg::START_FID1: fid_ok = state_reg.field_ident;
            default: fid_ok = 1'b1;
        endcase
    end

    // field only counts together with the window offsets
    assign go_cond = ~state_reg.need_v & win_ok & fid_ok;

    always_comb begin
        logic pick_b;
        logic pick_any;
        sts_pkg::sts_task_cfg_t pick_cfg;
        pick_b = 1'b0;
        pick_any = 1'b0;
        pick_cfg = state_reg.cfg_a;
        state_next = state_reg;

        // bus slave: one wait state, unmapped reads give zero, writes land as ack is seen
        state_next.ack = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        if (state_next.ack) begin
            case (idx)
                sts_pkg::IDX_GLOBAL: state_next.dat = {24'h000000, state_reg.global_ctl};
                sts_pkg::IDX_RESET: state_next.dat = {24'h000000, state_reg.reset_ctl};
                sts_pkg::IDX_STATUS: state_next.dat = {24'h000000, 1'b0, state_reg.field_ident,
                    state_reg.toggle_b, state_reg.toggle_a, state_reg.task_b,
                    state_reg.active, state_reg.state};
                sts_pkg::IDX_TASK_A: state_next.dat = {24'h000000, state_reg.cfg_a};
                sts_pkg::IDX_TRIG: state_next.dat = {24'h000000, state_reg.trig_ctl};
                sts_pkg::IDX_TASK_B: state_next.dat = {24'h000000, state_reg.cfg_b};
                default: state_next.dat = 32'h00000000;
            endcase
        end
        if (state_reg.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
            case (idx)
                sts_pkg::IDX_GLOBAL: state_next.global_ctl = wb_dat_i[7:0];
                sts_pkg::IDX_RESET: state_next.reset_ctl = wb_dat_i[7:0];
                sts_pkg::IDX_TASK_A: state_next.cfg_a = sts_pkg::sts_task_cfg_t'(wb_dat_i[7:0]);
                sts_pkg::IDX_TRIG: state_next.trig_ctl = wb_dat_i[7:0];
                sts_pkg::IDX_TASK_B: state_next.cfg_b = sts_pkg::sts_task_cfg_t'(wb_dat_i[7:0]);
                default: state_next.dat = state_next.dat;
            endcase
        end

        // field ident follows the source in use
        if (ext_src) begin
            if (vref_fall) begin
                state_next.field_ident = ext_decoder_hsync_ref_i;
            end
        end else begin
            state_next.field_ident = dec_field_i;
        end

        // task choice: second page wins when preferred or alone
        if (state_reg.global_ctl[sts_pkg::GL_SECOND_EN_BIT] &&
            (state_reg.prefer_b || !state_reg.global_ctl[sts_pkg::GL_FIRST_EN_BIT])) begin
            pick_b = 1'b1;
            pick_any = 1'b1;
            pick_cfg = state_reg.cfg_b;
        end else if (state_reg.global_ctl[sts_pkg::GL_FIRST_EN_BIT]) begin
            pick_any = 1'b1;
        end

        if (!soft_reset_n) begin
            // no wait for the running task: everything drops to idle now
            state_next.state = sts_pkg::ST_IDLE;
            state_next.active = 1'b0;
            state_next.prefer_b = 1'b1;
            state_next.repeated = 1'b0;
            state_next.need_v = 1'b0;
            state_next.skip = 3'h0;
            state_next.toggle_a = 1'b0;
            state_next.toggle_b = 1'b0;
        end else begin
            case (state_reg.state)
                sts_pkg::ST_IDLE: begin
                    // enables are only looked at here, between tasks
                    if (pick_any) begin
                        state_next.task_b = pick_b;
                        state_next.prefer_b = ~pick_b;
                        state_next.repeated = 1'b0;
                        state_next.skip = pick_cfg.field_skip_count;
                        state_next.need_v = (pick_cfg.start_condition == sts_pkg::START_VSYNC)
                            | offsets_passed_i;
                        state_next.state = sts_pkg::ST_WAIT;
                    end
                end
                sts_pkg::ST_WAIT: begin
                    // trigger conditions are evaluated only in this state
                    if (vsync_evt) begin
                        state_next.need_v = 1'b0;
                    end
                    if (go_cond) begin
                        if (state_reg.skip != 3'h0) begin
                            state_next.skip = state_reg.skip - 3'h1;
                            state_next.need_v = 1'b1;
                        end else begin
                            state_next.active = 1'b1;
                            state_next.state = sts_pkg::ST_RUN;
                            // free running, never realigned to the input field
                            if (state_reg.task_b) begin
                                state_next.toggle_b = ~state_reg.toggle_b;
                            end else begin
                                state_next.toggle_a = ~state_reg.toggle_a;
                            end
                        end
                    end
                end
                sts_pkg::ST_RUN: begin
                    if (task_done_i) begin
                        state_next.active = 1'b0;
                        if (cur_cfg.repeat_task && !state_reg.repeated) begin
                            state_next.repeated = 1'b1;
                            state_next.skip = cur_cfg.field_skip_count;
                            state_next.need_v = (cur_cfg.start_condition == sts_pkg::START_VSYNC)
                                | offsets_passed_i;
                            state_next.state = sts_pkg::ST_WAIT;
                        end else begin
                            state_next.state = sts_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_next.state = sts_pkg::ST_IDLE;
                end
            endcase
        end

        // stream marking, one cycle behind the task state
        state_next.d6 = cur_cfg.out_field_id_sel ? cur_toggle : state_reg.field_ident;
        state_next.d7 = ~cur_cfg.task_marker_invert;
        case (sts_pkg::sts_gp_mode_t'(state_reg.reset_ctl[sts_pkg::RS_GP0_LSB +: 2]))
            sts_pkg::GP_FIELD: state_next.gp0 = state_next.d6;
            sts_pkg::GP_TASK: state_next.gp0 = cur_cfg.task_marker_invert;
            default: state_next.gp0 = 1'b0;
        endcase
        case (sts_pkg::sts_gp_mode_t'(state_reg.reset_ctl[sts_pkg::RS_GP1_LSB +: 2]))
            sts_pkg::GP_FIELD: state_next.gp1 = state_next.d6;
            sts_pkg::GP_TASK: state_next.gp1 = cur_cfg.task_marker_invert;
            default: state_next.gp1 = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.global_ctl <= sts_pkg::GLOBAL_RST;
            state_reg.reset_ctl <= sts_pkg::RESET_RST;
            state_reg.trig_ctl <= sts_pkg::TRIG_RST;
            state_reg.cfg_a <= sts_pkg::sts_task_cfg_t'(sts_pkg::TASK_RST);
            state_reg.cfg_b <= sts_pkg::sts_task_cfg_t'(sts_pkg::TASK_RST);
            state_reg.state <= sts_pkg::ST_IDLE;
            state_reg.prefer_b <= 1'b1;
            state_reg.d7 <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.dat;
    assign task_active_o = state_reg.active;
    assign task_b_sel_o = state_reg.task_b;
    assign sav_d6_o = state_reg.d6;
    assign sav_d7_o = state_reg.d7;
    assign gp_out_pin_0_o = state_reg.gp0;
    assign gp_out_pin_1_o = state_reg.gp1;

    // checks
    ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse one cycle after request");

    soft_reset_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !soft_reset_n |=> state_reg.state == sts_pkg::ST_IDLE && !task_active_o && state_reg.prefer_b)
        else $error("soft reset did not force idle");

    run_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg.state == sts_pkg::ST_RUN && !task_done_i && soft_reset_n)
        |=> state_reg.state == sts_pkg::ST_RUN && $stable(task_b_sel_o))
        else $error("running task left before completion");

    start_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg.state == sts_pkg::ST_WAIT && soft_reset_n && go_cond && state_reg.skip == 3'h0)
        |=> task_active_o)
        else $error("task did not start when its condition held");

    start_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(task_active_o) |-> $past(win_ok) && $past(fid_ok) && !$past(state_reg.need_v))
        else $error("task started without window or field match");

    skip_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg.state == sts_pkg::ST_WAIT && soft_reset_n && go_cond && state_reg.skip != 3'h0)
        |=> !task_active_o && state_reg.need_v && state_reg.skip == $past(state_reg.skip) - 3'h1)
        else $error("field skip not applied");

    toggle_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(task_active_o) |-> (task_b_sel_o ? state_reg.toggle_b != $past(state_reg.toggle_b)
                                             : state_reg.toggle_a != $past(state_reg.toggle_a)))
        else $error("toggle flag did not flip on activation");

    repeat_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg.state == sts_pkg::ST_RUN && task_done_i && soft_reset_n
         && cur_cfg.repeat_task && !state_reg.repeated)
        |=> state_reg.state == sts_pkg::ST_WAIT && $stable(task_b_sel_o) && state_reg.repeated)
        else $error("repeat did not rerun the same task");

    prio_second_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg.state == sts_pkg::ST_IDLE && soft_reset_n && state_reg.prefer_b
         && state_reg.global_ctl[sts_pkg::GL_SECOND_EN_BIT]) |=> task_b_sel_o)
        else $error("task B not chosen first");

    d7_mark_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 sav_d7_o == !$past(cur_cfg.task_marker_invert))
        else $error("D7 does not follow the marker bit");

    d6_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 sav_d6_o == ($past(cur_cfg.out_field_id_sel) ? $past(cur_toggle) : $past(state_reg.field_ident)))
        else $error("D6 does not follow the selected field source");

    start_a_c: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(task_active_o) && !task_b_sel_o);
    start_b_c: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(task_active_o) && task_b_sel_o);
    repeat_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state_reg.repeated && $rose(task_active_o));
    skip_c: cover property (@(posedge clk_i) disable iff (rst_i)
        state_reg.state == sts_pkg::ST_WAIT && go_cond && state_reg.skip != 3'h0);
endmodule // sts_task_sequencer
`default_nettype wire

// ==== sts_pkg.sv ====
// package: register map, field layout and types of the scaler task sequencer
package sts_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_GLOBAL = 8'h80;
    localparam logic [7:0] IDX_RESET = 8'h88;
    localparam logic [7:0] IDX_STATUS = 8'h8f;
    localparam logic [7:0] IDX_TASK_A = 8'h90;
    localparam logic [7:0] IDX_TRIG = 8'h92;
    localparam logic [7:0] IDX_TASK_B = 8'hc0;

    // bit positions
    localparam int unsigned GL_EXT_SRC_BIT = 0;
    localparam int unsigned GL_FIRST_EN_BIT = 4;
    localparam int unsigned GL_SECOND_EN_BIT = 5;
    localparam int unsigned RS_GP0_LSB = 0;
    localparam int unsigned RS_GP1_LSB = 2;
    localparam int unsigned RS_SOFT_RESET_BIT = 5;
    localparam int unsigned TR_HTRIG_BIT = 2;
    localparam int unsigned TR_VTRIG_LO_BIT = 4;
    localparam int unsigned TR_VTRIG_HI_BIT = 5;

    // reset values
    localparam logic [7:0] GLOBAL_RST = 8'h00;
    localparam logic [7:0] RESET_RST = 8'h20;
    localparam logic [7:0] TRIG_RST = 8'h00;
    localparam logic [7:0] TASK_RST = 8'h00;

    // earliest start lines, counted from the vertical trigger
    localparam logic [7:0] LINE_DEC_BASE_50 = 8'h02;
    localparam logic [7:0] LINE_DEC_BASE_60 = 8'h05;
    localparam logic [7:0] LINE_DEC_F1_50 = 8'h04;
    localparam logic [7:0] LINE_DEC_F1_60 = 8'h07;
    localparam logic [7:0] LINE_DEC_F2_50 = 8'h03;
    localparam logic [7:0] LINE_DEC_F2_60 = 8'h06;
    localparam logic [7:0] LINE_EXT_50 = 8'h17;
    localparam logic [7:0] LINE_EXT_60 = 8'h14;

    // per-task control byte, msb first
    typedef struct packed {
        logic task_marker_invert;
        logic out_field_id_sel;
        logic [2:0] field_skip_count;
        logic repeat_task;
        logic [1:0] start_condition;
    } sts_task_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } sts_state_t;

    typedef enum logic [1:0] {
        GP_LOW = 2'b00,
        GP_FIELD = 2'b01,
        GP_TASK = 2'b10
    } sts_gp_mode_t;

    localparam logic [1:0] START_NOW = 2'b00;
    localparam logic [1:0] START_VSYNC = 2'b01;
    localparam logic [1:0] START_FID0 = 2'b10;
    localparam logic [1:0] START_FID1 = 2'b11;

    typedef struct packed {
        logic prev;
    } sts_edge_st_t;

    typedef struct packed {
        logic [7:0] cnt;
    } sts_gate_st_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [7:0] global_ctl;
        logic [7:0] reset_ctl;
        logic [7:0] trig_ctl;
        sts_task_cfg_t cfg_a;
        sts_task_cfg_t cfg_b;
        sts_state_t state;
        logic task_b;
        logic prefer_b;
        logic repeated;
        logic need_v;
        logic [2:0] skip;
        logic toggle_a;
        logic toggle_b;
        logic field_ident;
        logic active;
        logic d6;
        logic d7;
        logic gp0;
        logic gp1;
    } sts_core_t;

endpackage

// ==== sts_edge.sv ====
// rising and falling edge detector for one synchronous input
`timescale 1ns/1ns
`default_nettype none
module sts_edge (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // signal
    input wire logic sig_i,
    output logic rise_o,
    output logic fall_o
);
    sts_pkg::sts_edge_st_t state_reg;
    sts_pkg::sts_edge_st_t state_next;

    always_comb begin
        state_next.prev = sig_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.prev <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_o = sig_i & ~state_reg.prev;
    assign fall_o = ~sig_i & state_reg.prev;
endmodule // sts_edge
`default_nettype wire

// ==== sts_line_gate.sv ====
// line counter since the vertical trigger; flags the earliest start line
`timescale 1ns/1ns
`default_nettype none
module sts_line_gate (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // events
    input wire logic clear_i,
    input wire logic line_i,
    input wire logic [7:0] thresh_i,
    output logic ok_o
);
    sts_pkg::sts_gate_st_t state_reg;
    sts_pkg::sts_gate_st_t state_next;

    always_comb begin
        state_next = state_reg;
        if (clear_i) begin
            state_next.cnt = 8'h00;
        end else if (line_i && state_reg.cnt != 8'hff) begin
            // saturates so a long field never wraps back below the threshold
            state_next.cnt = state_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.cnt <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ok_o = state_reg.cnt >= thresh_i;
endmodule // sts_line_gate
`default_nettype wire

// ==== sts_backend_model.sv ====
// back-end model: ends each running task after a fixed number of cycles
`timescale 1ns/1ns
`default_nettype none
module sts_backend_model #(
    parameter int LEN = 40
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // task handshake
    input wire logic task_active_i,
    output logic task_done_o
);
    logic [7:0] cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || !task_active_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    // one-cycle done; a held level would end the next task at once
    assign task_done_o = task_active_i && (cnt_reg == 8'(LEN - 1));
endmodule // sts_backend_model
`default_nettype wire

// ==== sts_task_sequencer_test.sv ====
// testbench for the scaler task sequencer
`timescale 1ns/1ns
`default_nettype none
module sts_task_sequencer_test;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, vp = 0, hs = 0, fld = 0;
    logic s60 = 0, vo = 1, ho = 1;
    logic done, ack, act, bsel, d6, d7, g0, g1;
    logic [3:0] sel = 4'hf;
    logic [9:0] adr = 10'h000;
    logic [31:0] wd = 32'h0, rd, q;
    int fails = 0, cmp_count = 0;
    always #5 clk = ~clk;
    // external stream shares the decoder stimulus: vref, decoder_hsync_ref and sav follow vp, fld and hs
    sts_task_sequencer sts_task_sequencer_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel),
        .wb_dat_o(rd), .wb_ack_o(ack), .decoder_vertical_pulse_i(vp),
        .decoder_hsync_ref_i(hs), .dec_field_i(fld), .std_60hz_i(s60), .ext_vref_i(vp),
        .ext_decoder_hsync_ref_i(fld), .ext_sav_i(hs), .vert_offset_reached_i(vo),
        .horz_offset_reached_i(ho), .offsets_passed_i(1'b1), .task_done_i(done),
        .task_active_o(act), .task_b_sel_o(bsel), .sav_d6_o(d6), .sav_d7_o(d7),
        .gp_out_pin_0_o(g0), .gp_out_pin_1_o(g1));
    sts_backend_model #(.LEN(40)) sts_backend_model_inst (.clk_i(clk), .rst_i(rst),
        .task_active_i(act), .task_done_o(done));
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // classic single cycle; waits for ack without assuming its latency
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rd;
        cyc <= 0;
        stb <= 0;
        if (n == 50) fails++;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [9:0] a, input logic [7:0] e);
        wb(0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task automatic hpulse;
        hs <= 1;
        @(posedge clk);
        hs <= 0;
        repeat (3) @(posedge clk);
    endtask
    // one field: vertical trigger, then lines; run says whether the task must start
    task automatic frame(input logic f, input int lines, input logic run, b, e6, e7);
        int n = 0;
        fld <= f;
        vp <= 1;
        repeat (2) @(posedge clk);
        vp <= 0;
        repeat (2) @(posedge clk);
        repeat (lines - 1) hpulse();
        chk(act, 0);
        hpulse();
        while (act !== run && n < 10) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        chk(act, run);
        if (run) begin
            chk(bsel, b);
            chk(d6, e6);
            chk(g1, e6);
            chk(d7, e7);
            chk(g0, !e7);
        end
    endtask
    initial begin
        static logic [3:0] bv = 4'b0101, fv = 4'b0100, e6v = 4'b0110, e7v = 4'b1010;
        repeat (20) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rchk(10'h200, 8'h00);
        rchk(10'h220, 8'h20);
        rchk(10'h240, 8'h00);
        rchk(10'h300, 8'h00);
        rchk(10'h204, 8'h00);
        wb(1, 10'h220, 8'h26);
        wb(1, 10'h248, 8'h00);
        wb(1, 10'h240, 8'h40);
        wb(1, 10'h300, 8'h80);
        // byte lane 0 disabled: the write must be ignored
        sel <= 4'he;
        wb(1, 10'h240, 8'hff);
        sel <= 4'hf;
        rchk(10'h240, 8'h40);
        wb(1, 10'h200, 8'h30);
        for (int i = 0; i < 4; i++) begin
            if (i > 0) repeat (60) @(posedge clk);
            frame(fv[i], 2, 1, bv[i], e6v[i], e7v[i]);
        end
        // soft reset while task A runs must drop it without waiting for done
        wb(1, 10'h220, 8'h06);
        repeat (2) @(posedge clk);
        chk(act, 0);
        wb(1, 10'h220, 8'h26);
        frame(0, 2, 1, 1, 0, 0);
        // reprogram task B under soft reset: skip one field, repeat, start on field 1
        wb(1, 10'h220, 8'h06);
        rchk(10'h23c, 8'h08);
        wb(1, 10'h300, 8'h8f);
        wb(1, 10'h248, 8'h10);
        wb(1, 10'h220, 8'h26);
        frame(0, 4, 0, 0, 0, 0);
        vo <= 0;
        frame(1, 3, 0, 0, 0, 0);
        vo <= 1;
        ho <= 0;
        repeat (3) @(posedge clk);
        chk(act, 0);
        ho <= 1;
        repeat (3) @(posedge clk);
        chk(act, 0);
        frame(1, 3, 1, 1, 1, 0);
        repeat (60) @(posedge clk);
        frame(1, 3, 0, 0, 0, 0);
        frame(1, 3, 1, 1, 1, 0);
        repeat (60) @(posedge clk);
        s60 <= 1;
        frame(0, 7, 1, 0, 1, 1);
        // external stream: field taken from decoder_hsync_ref at the vref fall, start at line 20
        wb(1, 10'h220, 8'h06);
        wb(1, 10'h300, 8'h80);
        wb(1, 10'h200, 8'h31);
        wb(1, 10'h220, 8'h26);
        frame(1, 20, 1, 1, 1, 0);
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        results();
    end
endmodule // sts_task_sequencer_test
`default_nettype wire
